//--- common/fault_sup_pkg.sv
// constants for the flyback fault supervisor: cycle counts, timer lengths
// assumes a 40 MHz core clock; analog thresholds live outside in comparators
package fault_sup_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned CLK_NS          = 25;
   // consecutive switching cycles that confirm a fault
   localparam int unsigned CONFIRM_CYCLES  = 7;
   // millisecond timers
   localparam int unsigned OVERLOAD_MS     = 120;
   localparam int unsigned SHORT_MS        = 30;
   localparam int unsigned EXT_LOW_MS      = 32;
   localparam int unsigned OVERLOAD_CLKS   = OVERLOAD_MS * (CLK_HZ / 1000);
   localparam int unsigned SHORT_CLKS      = SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned EXT_LOW_CLKS    = EXT_LOW_MS * (CLK_HZ / 1000);
   // sample delays and blanking in ns; AUX_DELAY_CLKS and UV_BLANK_CLKS in clocks
   localparam int unsigned SENSE_DELAY_NS  = 4000;
   localparam int unsigned SENSE_DELAY_CLKS = (SENSE_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LEB_NS          = 250;
   localparam int unsigned LEB_CLKS        = (LEB_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned AUX_DELAY_CLKS  = 40;
   localparam int unsigned UV_BLANK_CLKS   = 4096;
   typedef enum logic [1:0] {RUN, LATCHED, RESTART} sup_state_t;
endpackage

//--- rtl/flyback_fault_supervisor.sv
// fault supervision and gate gating for a current-mode flyback controller
// assumes comparator outputs arrive asynchronous; pwm gate request is on CLOCK
`timescale 1ns/1ps
module flyback_fault_supervisor #(
   parameter int unsigned OVERLOAD_CLKS = fault_sup_pkg::OVERLOAD_CLKS,
   parameter int unsigned SHORT_CLKS    = fault_sup_pkg::SHORT_CLKS,
   parameter int unsigned EXT_LOW_CLKS  = fault_sup_pkg::EXT_LOW_CLKS,
   parameter int unsigned UV_BLANK_CLKS = fault_sup_pkg::UV_BLANK_CLKS,
   parameter int unsigned AUX_DELAY     = fault_sup_pkg::AUX_DELAY_CLKS
) (
   input  wire logic CLOCK,
   input  wire logic RSTN,
   input  wire logic PWM_ON_REQ,
   input  wire logic PWM_OFF_REQ,
   input  wire logic AUX_OV_CMP,
   input  wire logic AUX_UV_CMP,
   input  wire logic OVERLOAD_CMP,
   input  wire logic FB_SHORT_CMP,
   input  wire logic FB_BURST_CMP,
   input  wire logic EXT_HIGH_CMP,
   input  wire logic EXT_LOW_CMP,
   input  wire logic LINE_OV_CMP,
   input  wire logic PEAK_CMP,
   input  wire logic SENSE_LOW_CMP,
   input  wire logic OTP_TRIP_CMP,
   input  wire logic OTP_RELEASE_CMP,
   input  wire logic VCC_HOLD_CMP,
   input  wire logic VCC_LOCKOUT_CMP,
   output logic      GATE,
   output logic      CHARGE_HIGH_EN,
   output logic      THERM_BIAS_EN,
   output logic      PROTECT,
   output logic      LEB_ACTIVE
);
   localparam int unsigned MS_W = $clog2(OVERLOAD_CLKS + 1);
   localparam int unsigned DW = 12;

   // refused at elaboration: zero short timer or aux delay, and sizes the counters below cannot hold
   if (SHORT_CLKS > OVERLOAD_CLKS || EXT_LOW_CLKS > OVERLOAD_CLKS || SHORT_CLKS == 0)
      $error("timer lengths out of range");
   if (AUX_DELAY < 1 || AUX_DELAY >= (1 << DW) || UV_BLANK_CLKS >= (1 << 24))
      $error("delay out of range");

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NI = 13;
   logic [NI-1:0] s1, s2;
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= {AUX_OV_CMP, AUX_UV_CMP, OVERLOAD_CMP, FB_SHORT_CMP, FB_BURST_CMP,
                EXT_HIGH_CMP, EXT_LOW_CMP, LINE_OV_CMP, PEAK_CMP, SENSE_LOW_CMP,
                OTP_TRIP_CMP, OTP_RELEASE_CMP, VCC_HOLD_CMP};
         s2 <= s1;
      end
   end
   logic aux_ov, aux_uv, overload, fb_short, fb_burst, ext_high, ext_low;
   logic line_ov, peak, sense_low, otp_trip, otp_rel, vcc_hold;
   assign {aux_ov, aux_uv, overload, fb_short, fb_burst, ext_high, ext_low,
           line_ov, peak, sense_low, otp_trip, otp_rel, vcc_hold} = s2;

   logic lk1, lockout;
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         lk1     <= 1'b1;
         lockout <= 1'b1;
      end else begin
         lk1     <= VCC_LOCKOUT_CMP;
         lockout <= lk1;
      end
   end

   // ----------------------------------------
   // gate, blanking and burst
   // ----------------------------------------
   logic       protect;
   logic [3:0] leb_cnt;
   logic       next_gate;
   always_comb begin
      next_gate = GATE;
      if (protect || lockout)
         next_gate = 1'b0;
      else if (!GATE && PWM_ON_REQ && !fb_burst)
         next_gate = 1'b1;
      else if (GATE && PWM_OFF_REQ && leb_cnt == '0)
         next_gate = 1'b0;
   end
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         GATE <= 1'b0;
      else
         GATE <= next_gate;
   end
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         leb_cnt <= '0;
      else if (!GATE && next_gate)
         leb_cnt <= 4'(fault_sup_pkg::LEB_CLKS);
      else if (leb_cnt != '0)
         leb_cnt <= leb_cnt - 4'h1;
   end
   assign LEB_ACTIVE = (leb_cnt != '0);

   logic gate_d;
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         gate_d <= 1'b0;
      else
         gate_d <= GATE;
   end
   wire rise = GATE & ~gate_d;
   wire fall = ~GATE & gate_d;

   // ----------------------------------------
   // delayed sample strobes
   // ----------------------------------------
   logic [DW-1:0] aux_dly, sns_dly;
   logic          aux_strobe, sns_strobe;
   function automatic logic [DW-1:0] step(input logic start, input logic [DW-1:0] c,
                                          input logic [DW-1:0] init);
      if (start)
         return init;
      else if (c != '0)
         return c - 12'h001;
      return c;
   endfunction
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         aux_dly <= '0;
         sns_dly <= '0;
      end else begin
         aux_dly <= step(fall, aux_dly, DW'(AUX_DELAY));
         sns_dly <= step(rise, sns_dly, DW'(fault_sup_pkg::SENSE_DELAY_CLKS));
      end
   end
   assign aux_strobe = (aux_dly == 12'h001);
   // sample only while gate still on, so short pulses take no sense sample
   assign sns_strobe = (sns_dly == 12'h001) && GATE;

   // ----------------------------------------
   // startup undervoltage blank
   // ----------------------------------------
   logic [23:0] uv_blank;
   always_ff @(posedge CLOCK) begin
      if (!RSTN || lockout)
         uv_blank <= 24'(UV_BLANK_CLKS);
      else if (uv_blank != '0)
         uv_blank <= uv_blank - 24'h000001;
   end
   wire uv_armed = (uv_blank == '0);

   // ----------------------------------------
   // consecutive cycle counters
   // ----------------------------------------
   function automatic logic [2:0] cyc(input logic ev, input logic cond,
                                      input logic [2:0] c);
      if (!ev)
         return c;
      else if (!cond)
         return 3'h0;
      else if (c != 3'(fault_sup_pkg::CONFIRM_CYCLES))
         return c + 3'h1;
      return c;
   endfunction
   logic [2:0] ov_c, uv_c, eh_c, lo_c, pk_c, ss_c;
   logic       peak_seen;
   always_ff @(posedge CLOCK) begin
      if (!RSTN || lockout)
         peak_seen <= 1'b0;
      else if (rise)
         peak_seen <= 1'b0;
      else if (GATE && !LEB_ACTIVE && peak)
         peak_seen <= 1'b1;
   end
   always_ff @(posedge CLOCK) begin
      if (!RSTN || lockout) begin
         ov_c <= '0;
         uv_c <= '0;
         eh_c <= '0;
         lo_c <= '0;
         pk_c <= '0;
         ss_c <= '0;
      end else begin
         ov_c <= cyc(aux_strobe, aux_ov, ov_c);
         uv_c <= cyc(aux_strobe, aux_uv && uv_armed, uv_c);
         eh_c <= cyc(fall, ext_high, eh_c);
         lo_c <= cyc(fall, line_ov, lo_c);
         pk_c <= cyc(fall, peak_seen, pk_c);
         ss_c <= cyc(sns_strobe, sense_low, ss_c);
      end
   end
   function automatic logic hit(input logic [2:0] c);
      return c == 3'(fault_sup_pkg::CONFIRM_CYCLES);
   endfunction

   // ----------------------------------------
   // millisecond timers
   // ----------------------------------------
   logic [MS_W-1:0] ol_t, el_t;
   logic            ol_hit, el_hit;
   wire [MS_W-1:0]  ol_lim = fb_short ? MS_W'(SHORT_CLKS) : MS_W'(OVERLOAD_CLKS);
   always_ff @(posedge CLOCK) begin
      if (!RSTN || lockout || !(overload || fb_short))
         ol_t <= '0;
      else if (ol_t < ol_lim)
         ol_t <= ol_t + 1'b1;
   end
   always_ff @(posedge CLOCK) begin
      if (!RSTN || lockout || !ext_low)
         el_t <= '0;
      else if (el_t != MS_W'(EXT_LOW_CLKS))
         el_t <= el_t + 1'b1;
   end
   assign ol_hit = (ol_t >= ol_lim) && (overload || fb_short);
   assign el_hit = (el_t == MS_W'(EXT_LOW_CLKS));

   // ----------------------------------------
   // internal overtemperature with hysteresis
   // ----------------------------------------
   logic otp;
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         otp <= 1'b0;
      else if (otp_trip)
         otp <= 1'b1;
      else if (otp_rel)
         otp <= 1'b0;
   end

   // ----------------------------------------
   // protection latch
   // ----------------------------------------
   wire any_fault = hit(ov_c) | hit(uv_c) | hit(eh_c) | hit(lo_c) | hit(pk_c) |
                    hit(ss_c) | ol_hit | el_hit | otp;
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         protect <= 1'b0;
      else if (any_fault)
         protect <= 1'b1;
      else if (lockout)
         protect <= 1'b0;
   end
   assign PROTECT = protect;

   // ----------------------------------------
   // supply maintain and thermistor bias
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         CHARGE_HIGH_EN <= 1'b0;
      else
         CHARGE_HIGH_EN <= vcc_hold && !protect;
   end
   always_ff @(posedge CLOCK) begin
      if (!RSTN)
         THERM_BIAS_EN <= 1'b0;
      else
         THERM_BIAS_EN <= 1'b1;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_trip;
      ##1 protect;
   endsequence
   property p_latch;
      @(posedge CLOCK) disable iff (!RSTN) protect |=> !GATE;
   endproperty
   a_latch: assert property (p_latch) else $error("gate on while protected");
   property p_hold;
      @(posedge CLOCK) disable iff (!RSTN) protect && !lockout && !any_fault |=> protect;
   endproperty
   a_hold: assert property (p_hold) else $error("protect dropped early");
   property p_cyc;
      @(posedge CLOCK) disable iff (!RSTN) hit(ov_c) && !lockout |-> s_trip;
   endproperty
   a_cyc: assert property (p_cyc) else $error("ov count did not trip");
   property p_leb;
      @(posedge CLOCK) disable iff (!RSTN) GATE && LEB_ACTIVE && !protect && !lockout |=> GATE;
   endproperty
   a_leb: assert property (p_leb) else $error("gate off in blanking");
   // two runs of five cover the ten blanking cycles
   sequence s_blank5;
      LEB_ACTIVE [*5];
   endsequence
   property p_lebt;
      @(posedge CLOCK) disable iff (!RSTN) rise |-> s_blank5 ##1 s_blank5 ##1 !LEB_ACTIVE;
   endproperty
   a_lebt: assert property (p_lebt) else $error("blanking length wrong");
   property p_burst;
      @(posedge CLOCK) disable iff (!RSTN) !GATE && fb_burst |=> !GATE;
   endproperty
   a_burst: assert property (p_burst) else $error("pulse in burst");
   property p_clr;
      @(posedge CLOCK) disable iff (!RSTN) fall && !ext_high && !lockout |=> eh_c == 3'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("counter not cleared");
   property p_tmr;
      @(posedge CLOCK) disable iff (!RSTN) !overload && !fb_short |=> ol_t == '0;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer not cleared");
   property p_uv;
      @(posedge CLOCK) disable iff (!RSTN) !uv_armed && !lockout |=> uv_c == 3'h0;
   endproperty
   a_uv: assert property (p_uv) else $error("uv counted in blank");
   property p_chg;
      @(posedge CLOCK) disable iff (!RSTN) vcc_hold && !protect |=> CHARGE_HIGH_EN;
   endproperty
   a_chg: assert property (p_chg) else $error("maintain charge missing");
endmodule

//--- test/flyback_fault_supervisor_test.sv
// self-checking bench for the fault supervisor with a power stage model
// assumes shortened timer parameters; inputs change at falling clock edges
`timescale 1ns/1ps
module flyback_fault_supervisor_test;
   localparam int OL = 200;
   localparam int SC = 50;
   localparam int EL = 60;
   logic       clock       = 1'b0;
   logic       rstn        = 1'b0;
   logic       on_req      = 1'b0;
   logic       off_req     = 1'b0;
   logic       fb_burst    = 1'b0;
   logic       otp_trip    = 1'b0;
   logic       otp_release = 1'b1;
   logic       vcc_hold    = 1'b0;
   logic       lockout     = 1'b0;
   logic [5:0] fsel        = 6'h00;
   logic [2:0] tsel        = 3'h0;
   logic       peak;
   logic       sense_low;
   logic       aux_ov;
   logic       aux_uv;
   logic       gate;
   logic       charge;
   logic       bias;
   logic       protect;
   logic       leb;
   int         gate_len    = 0;
   int         errors      = 0;
   int         checked     = 0;
   string      fname [6]   = '{"line_ov", "ext_high", "peak", "sense_short", "aux_ov", "aux_uv"};
   always #12.5 clock = ~clock;
   always @(posedge clock) if (gate) gate_len <= gate_len + 1;
   flyback_fault_supervisor #(.OVERLOAD_CLKS(OL), .SHORT_CLKS(SC), .EXT_LOW_CLKS(EL),
      .UV_BLANK_CLKS(500), .AUX_DELAY(40)) uut (
      .CLOCK(clock), .RSTN(rstn), .PWM_ON_REQ(on_req), .PWM_OFF_REQ(off_req),
      .AUX_OV_CMP(aux_ov), .AUX_UV_CMP(aux_uv), .OVERLOAD_CMP(tsel[0]),
      .FB_SHORT_CMP(tsel[1]), .FB_BURST_CMP(fb_burst), .EXT_HIGH_CMP(fsel[1]),
      .EXT_LOW_CMP(tsel[2]), .LINE_OV_CMP(fsel[0]), .PEAK_CMP(peak),
      .SENSE_LOW_CMP(sense_low), .OTP_TRIP_CMP(otp_trip), .OTP_RELEASE_CMP(otp_release),
      .VCC_HOLD_CMP(vcc_hold), .VCC_LOCKOUT_CMP(lockout), .GATE(gate),
      .CHARGE_HIGH_EN(charge), .THERM_BIAS_EN(bias), .PROTECT(protect), .LEB_ACTIVE(leb));
   power_stage_model stage (
      .clock(clock), .gate(gate), .sense_short(fsel[3]), .peak_fault(fsel[2]),
      .out_level({fsel[5], fsel[4]}), .peak_cmp(peak), .sense_low_cmp(sense_low),
      .aux_ov_cmp(aux_ov), .aux_uv_cmp(aux_uv));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // long on-time so the delayed sense strobe falls inside the pulse
   task automatic pulse();
      on_req = 1'b1;
      cyc(1);
      on_req = 1'b0;
      cyc(170);
      off_req = 1'b1;
      cyc(1);
      off_req = 1'b0;
      cyc(60);
   endtask
   task automatic recover(input logic exp);
      lockout = 1'b1;
      cyc(5);
      lockout = 1'b0;
      cyc(5);
      check("protect after lockout", protect, exp);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_blanking();
      gate_len = 0;
      on_req = 1'b1;
      off_req = 1'b1;
      cyc(1);
      on_req = 1'b0;
      cyc(1);
      check("leb", leb, 1'b1);
      cyc(20);
      off_req = 1'b0;
      check("gate on time", gate_len, fault_sup_pkg::LEB_CLKS + 1);
      cyc(50);
      $display("test blanking done");
   endtask
   task automatic test_faults();
      for (int k = 0; k < 6; k++) begin
         fsel = 6'h01 << k;
         repeat (6) pulse();
         fsel = 6'h00;
         pulse();
         fsel = 6'h01 << k;
         repeat (6) pulse();
         check(fname[k], protect, 1'b0);
         pulse();
         check(fname[k], protect, 1'b1);
         fsel = 6'h00;
         gate_len = 0;
         pulse();
         check("gate held off", gate_len, 0);
         recover(1'b0);
         $display("test %s done", fname[k]);
      end
   endtask
   task automatic test_timer(input string what, input logic [2:0] k, input int lim);
      repeat (2) begin
         tsel = k;
         cyc(lim - 10);
         tsel = 3'h0;
         cyc(3);
      end
      check(what, protect, 1'b0);
      tsel = k;
      cyc(lim - 3);
      check(what, protect, 1'b0);
      cyc(10);
      check(what, protect, 1'b1);
      tsel = 3'h0;
      recover(1'b0);
      $display("test %s done", what);
   endtask
   task automatic test_misc();
      otp_trip = 1'b1;
      otp_release = 1'b0;
      cyc(5);
      check("otp", protect, 1'b1);
      otp_trip = 1'b0;
      // inside the hysteresis band the die is still hot
      recover(1'b1);
      otp_release = 1'b1;
      recover(1'b0);
      fb_burst = 1'b1;
      cyc(3);
      gate_len = 0;
      pulse();
      check("burst gate", gate_len, 0);
      fb_burst = 1'b0;
      vcc_hold = 1'b1;
      cyc(4);
      check("charge on", charge, 1'b1);
      vcc_hold = 1'b0;
      cyc(4);
      check("charge off", charge, 1'b0);
      $display("test misc done");
   endtask
   initial begin
      cyc(6);
      rstn = 1'b1;
      cyc(4);
      check("bias", bias, 1'b1);
      check("protect", protect, 1'b0);
      test_blanking();
      test_faults();
      test_timer("overload", 3'h1, OL);
      test_timer("short", 3'h3, SC);
      test_timer("ext_low", 3'h4, EL);
      test_misc();
      summarize();
   end
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      summarize();
   end
endmodule

//--- test/power_stage_model.sv
// behavioural flyback power stage: switch current ramp, sense resistor, aux winding
// assumes gate is the supervisor's GATE; comparator outputs are seen as async inputs
`timescale 1ns/1ps
module power_stage_model (
   input  wire logic       clock,
   input  wire logic       gate,
   input  wire logic       sense_short,
   input  wire logic       peak_fault,
   input  wire logic [1:0] out_level,
   output logic            peak_cmp,
   output logic            sense_low_cmp,
   output logic            aux_ov_cmp,
   output logic            aux_uv_cmp
);
   logic [7:0] ramp  = 8'h00;
   logic [7:0] demag = 8'h00;
   // ----------------------------------------
   // current ramp and demagnetisation window
   // ----------------------------------------
   always @(posedge clock) begin
      if (!gate) begin
         ramp <= 8'h00;
      end else if (ramp != 8'hFF) begin
         ramp <= ramp + 8'h01;
      end
      // secondary conducts long enough to cover the aux strobe
      if (gate) begin
         demag <= 8'h3C;
      end else if (demag != 8'h00) begin
         demag <= demag - 8'h01;
      end
   end
   assign peak_cmp      = gate & peak_fault & (ramp > 8'h0C);
   // a shorted sense pin never lifts off ground
   assign sense_low_cmp = ~gate | sense_short | (ramp < 8'h03);
   assign aux_ov_cmp    = (demag != 8'h00) & (out_level == 2'h1);
   // aux rings near ground outside demagnetisation
   assign aux_uv_cmp    = (demag == 8'h00) | (out_level == 2'h2);
endmodule
